// ---- testbench/sccct_asserts.sv ----
// Port-level concurrent checks for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module sccct_asserts #(
   parameter W = 16
) (
   input wire logic         core_clk,                // Clock
   input wire logic         rst_n,                   // Reset
   input wire logic         count_run_enable,        // Run level
   input wire logic         soft_update_trigger,     // Forced update
   input wire logic         update_suppress,         // Update block
   input wire logic         update_irq_en,           // Update irq enable
   input wire logic [1:0]   capture_source_select,   // Mode select
   input wire logic         channel_gate_on,         // Channel enable
   input wire logic [2:0]   compare_output_function, // Function code
   input wire logic         debug_halt,              // Core halted
   input wire logic         debug_halt_hold,         // Freeze on halt
   input wire logic         channel_event_irq_en,    // Channel irq enable
   input wire logic [W-1:0] counter_value,           // Count
   input wire logic         update_flag,             // Update flag
   input wire logic         channel_event_flag,      // Channel flag
   input wire logic         output_prepare_level,    // Prepared level
   input wire logic         channel_out,             // Pin output
   input wire logic         channel_out_en,          // Pin enable
   input wire logic         update_irq,              // Update irq
   input wire logic         channel_irq              // Channel irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Trigger step, then zeroed count
   sequence s_trig; soft_update_trigger; endsequence
   sequence s_zero; counter_value == 16'h0000; endsequence
   // A wrap not caused by the trigger nor suppressed
   sequence s_wrap;
      $past(counter_value) != 16'h0000 && counter_value == 16'h0000
         && !$past(soft_update_trigger) && !$past(update_suppress);
   endsequence
   property p_trig_zero; s_trig |=> s_zero; endproperty
   property p_up_only; $changed(counter_value) |->
      (counter_value == $past(counter_value) + 16'h0001 || counter_value == 16'h0000); endproperty
   property p_wrap_flag; s_wrap |-> update_flag; endproperty
   property p_stop; !count_run_enable && !soft_update_trigger |=> $stable(counter_value); endproperty
   property p_halt; debug_halt && debug_halt_hold && !soft_update_trigger
      |=> $stable(counter_value); endproperty
   property p_suppress; update_suppress && !update_flag |=> !update_flag; endproperty
   property p_force; capture_source_select == 2'h0 && compare_output_function[2:1] == 2'h2
      |=> output_prepare_level == $past(compare_output_function[0]); endproperty
   property p_pin; channel_out_en == (channel_gate_on && capture_source_select == 2'h0)
      && channel_out == output_prepare_level; endproperty
   property p_upd_irq; update_irq == (update_flag && update_irq_en); endproperty
   property p_ch_irq; channel_irq == (channel_event_flag && channel_event_irq_en); endproperty
   a_trig_zero: assert property (p_trig_zero) else $error("count not zeroed");
   a_up_only: assert property (p_up_only) else $error("count did not step up");
   a_wrap_flag: assert property (p_wrap_flag) else $error("wrap without update");
   a_stop: assert property (p_stop) else $error("count moved while off");
   a_halt: assert property (p_halt) else $error("count moved in halt");
   a_suppress: assert property (p_suppress) else $error("update while blocked");
   a_force: assert property (p_force) else $error("forced level wrong");
   a_pin: assert property (p_pin) else $error("pin drive wrong");
   a_upd_irq: assert property (p_upd_irq) else $error("update irq wrong");
   a_ch_irq: assert property (p_ch_irq) else $error("channel irq wrong");
endmodule
bind sccct_top sccct_asserts #(.W(W)) i_chk (.core_clk, .rst_n, .count_run_enable,
   .soft_update_trigger, .update_suppress, .update_irq_en, .capture_source_select,
   .channel_gate_on, .compare_output_function, .debug_halt, .debug_halt_hold,
   .channel_event_irq_en, .counter_value, .update_flag, .channel_event_flag,
   .output_prepare_level, .channel_out, .channel_out_en, .update_irq, .channel_irq);
`default_nettype wire

// ---- testbench/sccct_pin_model.sv ----
// Square wave source on the channel pin
`timescale 1ns/1ps
`default_nettype none
module sccct_pin_model (
   input  wire logic       core_clk,      // Clock
   input  wire logic       rst_n,         // Reset
   input  wire logic       go,            // Run the wave
   input  wire logic [7:0] half,          // Cycles per level
   output var  logic       channel_input  // Pin level
);
   logic [7:0] cnt_q;
   // Source holds its last level when stopped, like a driven line
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         channel_input <= 1'b0;
      end else if (go && cnt_q == half - 8'h01) begin
         cnt_q <= 8'h00;
         channel_input <= !channel_input;
      end else begin
         cnt_q <= go ? cnt_q + 8'h01 : 8'h00;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench of the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        core_clk, rst_n, count_run_enable, reload_shadow_on, soft_update_trigger;
   logic        update_suppress, update_irq_en, update_flag_clr, edge_polarity_select;
   logic        complementary_polarity_select, channel_gate_on, compare_shadow_on;
   logic        compare_wr, compare_rd, channel_soft_event, channel_event_irq_en;
   logic        channel_flag_clr, overrun_flag_clr, debug_halt, debug_halt_hold, pin_go;
   logic [15:0] prescale_divisor, reload_limit, compare_wr_data;
   logic [1:0]  capture_source_select, input_edge_div;
   logic [3:0]  input_filter_setting;
   logic [2:0]  compare_output_function;
   logic [7:0]  pin_half;
   logic [15:0] counter_value, channel_value_register;
   logic        update_flag, channel_event_flag, channel_overrun_flag, output_prepare_level;
   logic        channel_out, channel_out_en, update_irq, channel_irq, channel_dma_req;
   wire logic   channel_input;
   int          failures, total_checks, cycles, n;
   sccct_top i_dut (.core_clk, .rst_n, .count_run_enable, .prescale_divisor, .reload_limit,
      .reload_shadow_on, .soft_update_trigger, .update_suppress, .update_irq_en,
      .update_flag_clr, .capture_source_select, .input_filter_setting, .input_edge_div,
      .edge_polarity_select, .complementary_polarity_select, .channel_gate_on,
      .compare_output_function, .compare_shadow_on, .compare_wr_data, .compare_wr,
      .compare_rd, .channel_soft_event, .channel_event_irq_en, .channel_flag_clr,
      .overrun_flag_clr, .debug_halt, .debug_halt_hold, .channel_input, .counter_value,
      .channel_value_register, .update_flag, .channel_event_flag, .channel_overrun_flag,
      .output_prepare_level, .channel_out, .channel_out_en, .update_irq, .channel_irq,
      .channel_dma_req);
   sccct_pin_model i_pin (.core_clk, .rst_n, .go(pin_go), .half(pin_half), .channel_input);
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = !core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         tally_and_finish;
      end
   end
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task cyc(input int k); repeat (k) @(negedge core_clk); endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   // Clears the channel flag, then counts cycles until it sets again
   task automatic wait_ev(output int k);
      k = 0;
      channel_flag_clr = 1'b1;
      do begin
         cyc(1);
         if (k == 0) channel_flag_clr = 1'b0;
         k++;
      end while (channel_event_flag !== 1'b1 && k < 300);
      if (k >= 300) chk("event wait", 16'h0, 16'h1);
   endtask
   // Cycles between two counter steps, first step only syncs
   task automatic per(output int k);
      logic [15:0] c;
      repeat (2) begin
         c = counter_value;
         k = 0;
         while (counter_value === c && k < 9) begin cyc(1); k++; end
      end
   endtask
   task t_count;
      reload_limit = 16'h0002;
      pulse(soft_update_trigger);
      pulse(update_flag_clr);
      count_run_enable = 1'b1;
      n = 0;
      while (counter_value !== 16'h0001 && n < 10) begin cyc(1); n++; end
      cyc(1);
      chk("count", counter_value, 16'h0002);
      chk("upd flag early", update_flag, 16'h0);
      update_irq_en = 1'b1;
      cyc(1);
      chk("wrap", counter_value, 16'h0000);
      chk("upd flag", update_flag, 16'h1);
      chk("upd irq", update_irq, 16'h1);
      {debug_halt, debug_halt_hold} = 2'h3;
      cyc(3);
      chk("halted", counter_value, 16'h0000);
      debug_halt = 1'b0;
      cyc(1);
      chk("resumed", counter_value, 16'h0001);
      count_run_enable = 1'b0;
      cyc(3);
      chk("stopped", counter_value, 16'h0001);
   endtask
   task t_presc;
      reload_limit = 16'h00ff;
      prescale_divisor = 16'h0002;
      count_run_enable = 1'b1;
      per(n);
      chk("old divisor", n, 16'd1);
      pulse(soft_update_trigger);
      per(n);
      chk("new divisor", n, 16'd3);
   endtask
   task automatic t_cmp;
      logic [3:0] tb [7] = '{4'hd, 4'h2, 4'h9, 4'h3, 4'hb, 4'h8, 4'h4};
      prescale_divisor = 16'h0000;
      reload_limit = 16'h0009;
      pulse(soft_update_trigger);
      compare_wr_data = 16'h0003;
      pulse(compare_wr);
      channel_event_irq_en = 1'b1;
      for (int i = 0; i < 7; i++) begin
         compare_output_function = tb[i][2:0];
         wait_ev(n);
         chk("match count", counter_value, 16'h0004);
         chk("level", output_prepare_level, tb[i][3]);
         chk("ch irq", channel_irq, 16'h1);
      end
   endtask
   task automatic pwm(input logic [2:0] fn, input logic [15:0] cmp);
      logic [15:0] prev;
      compare_output_function = fn;
      cyc(2);
      prev = counter_value;
      repeat (20) begin
         cyc(1);
         chk("pwm", output_prepare_level, (prev < cmp) ^ fn[0]);
         prev = counter_value;
      end
   endtask
   task t_pwm;
      pwm(3'h6, 16'h0003);
      pwm(3'h7, 16'h0003);
      update_suppress = 1'b1;
      compare_shadow_on = 1'b1;
      compare_wr_data = 16'h0007;
      pulse(compare_wr);
      pulse(update_flag_clr);
      pwm(3'h6, 16'h0003);
      pulse(soft_update_trigger);
      chk("trig zero", counter_value, 16'h0000);
      chk("blocked", update_flag, 16'h0);
      update_suppress = 1'b0;
      cyc(12);
      chk("upd again", update_flag, 16'h1);
      pwm(3'h6, 16'h0007);
   endtask
   task t_cap;
      reload_limit = 16'h00ff;
      pulse(soft_update_trigger);
      n = 0;
      while (counter_value !== 16'h0005 && n < 20) begin cyc(1); n++; end
      count_run_enable = 1'b0;
      {capture_source_select, input_filter_setting, channel_gate_on} = 7'h25;
      {pin_half, pin_go} = 9'h011;
      wait_ev(n);
      chk("capture", channel_value_register, 16'h0005);
      chk("no overrun", channel_overrun_flag, 16'h0);
      pulse(compare_rd);
      chk("read clears", channel_event_flag, 16'h0);
      compare_wr_data = 16'h1234;
      pulse(compare_wr);
      chk("read only", channel_value_register, 16'h0005);
      cyc(35);
      chk("overrun", channel_overrun_flag, 16'h1);
      {complementary_polarity_select, input_edge_div} = 3'h6;
      wait_ev(n);
      wait_ev(n);
      chk("both edges by 4", n, 16'd32);
      {complementary_polarity_select, edge_polarity_select, input_edge_div} = 4'h4;
      wait_ev(n);
      wait_ev(n);
      chk("falling", n, 16'd16);
      channel_gate_on = 1'b0;
      pulse(channel_flag_clr);
      cyc(40);
      chk("gated", channel_event_flag, 16'h0);
      pulse(channel_soft_event);
      chk("dma", channel_dma_req, 16'h1);
      cyc(1);
      chk("dma end", channel_dma_req, 16'h0);
      chk("soft event", channel_event_flag, 16'h1);
      chk("soft irq", channel_irq, 16'h1);
   endtask
   task tally_and_finish;
      if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      {rst_n, count_run_enable, reload_shadow_on, soft_update_trigger, update_suppress} = '0;
      {update_irq_en, update_flag_clr, edge_polarity_select, complementary_polarity_select} = '0;
      {channel_gate_on, compare_shadow_on, compare_wr, compare_rd, channel_soft_event} = '0;
      {channel_event_irq_en, channel_flag_clr, overrun_flag_clr, debug_halt} = '0;
      {debug_halt_hold, pin_go, pin_half, compare_output_function} = '0;
      {prescale_divisor, reload_limit, compare_wr_data} = '0;
      {capture_source_select, input_edge_div, input_filter_setting} = '0;
      {failures, total_checks, cycles} = '0;
      cyc(6);
      rst_n = 1'b1;
      cyc(1);
      t_count;
      t_presc;
      t_cmp;
      t_pwm;
      t_cap;
      tally_and_finish;
   end
endmodule
`default_nettype wire

// ---- verilog/sccct_defines.vh ----
// Constants of the single channel capture compare timer
`ifndef SCCCT_DEFINES_VH
`define SCCCT_DEFINES_VH
`define SCCCT_CNT_W       16
`define SCCCT_ZERO16      16'h0000
`define SCCCT_ONE16       16'h0001
`define SCCCT_FLT_W       4
`define SCCCT_ICPSC_W     2
`define SCCCT_SRC_W       2
`define SCCCT_SRC_OUTPUT  2'h0
`define SCCCT_FN_W        3
`define SCCCT_FN_FROZEN   3'h0
`define SCCCT_FN_SET      3'h1
`define SCCCT_FN_CLEAR    3'h2
`define SCCCT_FN_TOGGLE   3'h3
`define SCCCT_FN_FORCE_LO 3'h4
`define SCCCT_FN_FORCE_HI 3'h5
`define SCCCT_FN_PWM0     3'h6
`define SCCCT_FN_PWM1     3'h7
`endif

// ---- verilog/sccct_input_stage.v ----
// Channel input synchroniser, filter, edge select and event prescaler
`timescale 1ns/1ps
`default_nettype none
`include "sccct_defines.vh"
module sccct_input_stage (
   input  wire                      core_clk,      // Timer kernel clock
   input  wire                      rst_n,         // Async reset, active low
   input  wire                      channel_input, // Raw channel pin level
   input  wire [`SCCCT_FLT_W-1:0]   filt_setting,  // Stable samples needed minus one
   input  wire                      pol_fall,      // Edge polarity: 1 falling
   input  wire                      pol_both,      // Complementary polarity: both edges
   input  wire [`SCCCT_ICPSC_W-1:0] edge_div,      // Edges per capture: 1,2,4,8
   input  wire                      enable,        // Channel gate and input mode
   output wire                      capture        // One cycle capture event
);
   reg                    sync1_q;
   reg                    sync2_q;
   reg                    filt_q;
   reg [`SCCCT_FLT_W-1:0] stab_q;
   reg [3:0]              ecnt_q;
   wire                   rise;
   wire                   fall;
   wire                   qual;
   wire [3:0]             need;

   // Two flops before anything looks at the pin
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= channel_input;
         sync2_q <= sync1_q;
      end
   end

   // Filter: new level accepted after setting+1 stable samples
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_q <= 1'b0;
         stab_q <= {`SCCCT_FLT_W{1'b0}};
      end else if (sync2_q == filt_q) begin
         stab_q <= {`SCCCT_FLT_W{1'b0}};
      end else if (stab_q >= filt_setting) begin
         filt_q <= sync2_q;
         stab_q <= {`SCCCT_FLT_W{1'b0}};
      end else begin
         stab_q <= stab_q + 1'b1;
      end
   end

   assign rise = sync2_q && !filt_q && (stab_q >= filt_setting);
   assign fall = !sync2_q && filt_q && (stab_q >= filt_setting);
   // Polarity picks the qualifying edge
   assign qual = enable && (pol_both ? (rise || fall) : (pol_fall ? fall : rise));
   assign need = 4'h1 << edge_div;

   // Several qualified edges make one capture
   assign capture = qual && (ecnt_q == need - 4'h1);
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ecnt_q <= 4'h0;
      end else if (!enable || capture) begin
         ecnt_q <= 4'h0;
      end else if (qual) begin
         ecnt_q <= ecnt_q + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/sccct_prescaler.v ----
// Clock prescaler with buffered divisor for the timer counter
`timescale 1ns/1ps
`default_nettype none
`include "sccct_defines.vh"
module sccct_prescaler #(
   parameter W = `SCCCT_CNT_W
) (
   input  wire         core_clk,      // Timer kernel clock
   input  wire         rst_n,         // Async reset, active low
   input  wire         run,           // Counting allowed this cycle
   input  wire         restart,       // Clear divider count
   input  wire         update,        // Load shadow divisor
   input  wire [W-1:0] divisor_buf,   // Buffered divisor value
   output wire         tick           // One count clock pulse
);
   reg [W-1:0] shadow_q;
   reg [W-1:0] cnt_q;

   // Terminal count reached; factor is shadow plus one
   assign tick = run && (cnt_q == shadow_q);

   // Shadow loads only on update, so a new divisor waits
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_q <= `SCCCT_ZERO16;
         cnt_q    <= `SCCCT_ZERO16;
      end else begin
         if (update) begin
            shadow_q <= divisor_buf;
         end
         if (restart || tick) begin
            cnt_q <= `SCCCT_ZERO16;
         end else if (run) begin
            cnt_q <= cnt_q + `SCCCT_ONE16;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verilog/sccct_top.v ----
// Single channel 16-bit capture/compare timer core
//
// Contract
// - 16-bit unsigned counter, up counting only.
// - Counter advances only while count_run_enable is set.
// - Prescaler divides kernel clock by 1 to 65536.
// - Division factor is prescale_divisor plus one.
// - New prescale value takes effect at next update event.
// - Counter runs 0 to reload_limit then wraps to 0.
// - Update event on every overflow wrap.
// - soft_update_trigger zeroes counter and makes update event.
// - update_suppress blocks update events and shadow loads.
// - Update event loads reload and prescale shadows.
// - Input synchronised, then digitally filtered before edge detection.
// - Rising/falling edges detected; polarity selects capture edge.
// - Input prescaler: several qualified edges give one capture.
// - Capture stores counter, sets channel flag, interrupt if enabled.
// - Nonzero capture source means input mode; value writes ignored.
// - Capture while channel flag set also sets overrun flag.
// - In input mode reading value register clears channel flag.
// - channel_soft_event produces channel event without condition.
// - channel_gate_on gates capture and output pin drive.
// - Compare match sets flag, interrupt, updates output per function.
// - Match codes: 0 keep, 1 high, 2 low, 3 toggle.
// - Codes 6 and 7 select PWM modes 0 and 1.
// - Codes 4 and 5 force level inactive or active.
// - Compare shadowing buffers value until next update event.
// - Debug halt with hold bit set stops the counter.
`timescale 1ns/1ps
`default_nettype none
`include "sccct_defines.vh"
module sccct_top #(
   parameter W = `SCCCT_CNT_W
) (
   input  wire                      core_clk,               // Timer kernel clock, 100 MHz
   input  wire                      rst_n,                  // Async reset, active low
   input  wire                      count_run_enable,       // Counter enable level
   input  wire [W-1:0]              prescale_divisor,       // Buffered prescale value
   input  wire [W-1:0]              reload_limit,           // Buffered auto-reload value
   input  wire                      reload_shadow_on,       // Reload buffered until update
   input  wire                      soft_update_trigger,    // Pulse: force update
   input  wire                      update_suppress,        // Block update events
   input  wire                      update_irq_en,          // Update interrupt enable
   input  wire                      update_flag_clr,        // Pulse: clear update flag
   input  wire [`SCCCT_SRC_W-1:0]   capture_source_select,  // 0 output, else input mode
   input  wire [`SCCCT_FLT_W-1:0]   input_filter_setting,   // Filter stable-sample count
   input  wire [`SCCCT_ICPSC_W-1:0] input_edge_div,         // Log2 edges per capture
   input  wire                      edge_polarity_select,   // Capture on falling edge
   input  wire                      complementary_polarity_select, // Capture on both edges
   input  wire                      channel_gate_on,        // Channel enable
   input  wire [`SCCCT_FN_W-1:0]    compare_output_function, // Compare function code
   input  wire                      compare_shadow_on,      // Compare value buffered
   input  wire [W-1:0]              compare_wr_data,        // Value register write data
   input  wire                      compare_wr,             // Pulse: write value register
   input  wire                      compare_rd,             // Pulse: read value register
   input  wire                      channel_soft_event,     // Pulse: force channel event
   input  wire                      channel_event_irq_en,   // Channel interrupt enable
   input  wire                      channel_flag_clr,       // Pulse: clear channel flag
   input  wire                      overrun_flag_clr,       // Pulse: clear overrun flag
   input  wire                      debug_halt,             // Core halted
   input  wire                      debug_halt_hold,        // Freeze counter on halt
   input  wire                      channel_input,          // Channel pin input
   output reg  [W-1:0]              counter_value,          // Current count
   output reg  [W-1:0]              channel_value_register, // Capture/compare value
   output reg                       update_flag,            // Sticky update flag
   output reg                       channel_event_flag,     // Sticky channel flag
   output reg                       channel_overrun_flag,   // Sticky over-capture flag
   output reg                       output_prepare_level,   // Compare output prepare
   output wire                      channel_out,            // Channel pin output
   output wire                      channel_out_en,         // Channel pin drive enable
   output wire                      update_irq,             // Update interrupt
   output wire                      channel_irq,            // Channel interrupt
   output reg                       channel_dma_req         // Pulse: channel request
);
   reg  [W-1:0] reload_q;
   reg  [W-1:0] compare_active_q;
   wire         input_mode;
   wire         halted;
   wire         run;
   wire         tick;
   wire         wrap;
   wire         update_ev;
   wire         capture;
   wire         match;
   wire         chan_ev;
   wire [W-1:0] reload_eff;

   // Live or shadowed value select, used for the comparator, PWM and reload limit
   function [W-1:0] sel_val;
      input          shadow;
      input [W-1:0]  live;
      input [W-1:0]  held;
      begin
         sel_val = shadow ? held : live;
      end
   endfunction

   assign input_mode = (capture_source_select != `SCCCT_SRC_OUTPUT);
   assign halted     = debug_halt && debug_halt_hold;
   assign run        = count_run_enable && !halted;
   assign reload_eff = sel_val(reload_shadow_on, reload_limit, reload_q);

   // Wrap after reaching the reload value
   assign wrap      = tick && (counter_value == reload_eff);
   // Suppress blocks the event, but the trigger still zeroes the counter
   assign update_ev = (wrap || soft_update_trigger) && !update_suppress;

   sccct_prescaler #(
      .W(W)
   ) u_psc (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .run         (run),
      .restart     (soft_update_trigger),
      .update      (update_ev),
      .divisor_buf (prescale_divisor),
      .tick        (tick)
   );

   sccct_input_stage u_in (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .channel_input (channel_input),
      .filt_setting  (input_filter_setting),
      .pol_fall      (edge_polarity_select),
      .pol_both      (complementary_polarity_select),
      .edge_div      (input_edge_div),
      .enable        (channel_gate_on && input_mode),
      .capture       (capture)
   );

   // Up counter; no down direction exists
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         counter_value <= `SCCCT_ZERO16;
      end else if (soft_update_trigger || wrap) begin
         counter_value <= `SCCCT_ZERO16;
      end else if (tick) begin
         counter_value <= counter_value + `SCCCT_ONE16;
      end
   end

   // Reload and compare shadows load on update only
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_q         <= `SCCCT_ZERO16;
         compare_active_q <= `SCCCT_ZERO16;
      end else if (update_ev) begin
         reload_q         <= reload_limit;
         compare_active_q <= channel_value_register;
      end
   end

   // Match is sampled once per count step to avoid repeat events
   assign match   = !input_mode && tick &&
                    (counter_value == sel_val(compare_shadow_on, channel_value_register,
                                              compare_active_q));
   assign chan_ev = capture || match || channel_soft_event;

   // Value register: capture load, or software write in output mode
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_value_register <= `SCCCT_ZERO16;
      end else if (capture) begin
         channel_value_register <= counter_value;
      end else if (compare_wr && !input_mode) begin
         channel_value_register <= compare_wr_data;
      end
   end

   // Sticky flags; a set in the clear cycle wins
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         update_flag          <= 1'b0;
         channel_event_flag   <= 1'b0;
         channel_overrun_flag <= 1'b0;
         channel_dma_req      <= 1'b0;
      end else begin
         if (update_ev) begin
            update_flag <= 1'b1;
         end else if (update_flag_clr) begin
            update_flag <= 1'b0;
         end
         if (chan_ev) begin
            channel_event_flag <= 1'b1;
         end else if (channel_flag_clr || (compare_rd && input_mode)) begin
            channel_event_flag <= 1'b0;
         end
         if (capture && channel_event_flag) begin
            channel_overrun_flag <= 1'b1;
         end else if (overrun_flag_clr) begin
            channel_overrun_flag <= 1'b0;
         end
         channel_dma_req <= chan_ev;
      end
   end

   // Output prepare level per compare function
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         output_prepare_level <= 1'b0;
      end else if (!input_mode) begin
         case (compare_output_function)
            `SCCCT_FN_FROZEN: output_prepare_level <= output_prepare_level;
            `SCCCT_FN_SET: begin
               if (match) output_prepare_level <= 1'b1;
            end
            `SCCCT_FN_CLEAR: begin
               if (match) output_prepare_level <= 1'b0;
            end
            `SCCCT_FN_TOGGLE: begin
               if (match) output_prepare_level <= !output_prepare_level;
            end
            `SCCCT_FN_FORCE_LO: output_prepare_level <= 1'b0;
            `SCCCT_FN_FORCE_HI: output_prepare_level <= 1'b1;
            `SCCCT_FN_PWM0: output_prepare_level <= (counter_value <
               sel_val(compare_shadow_on, channel_value_register, compare_active_q));
            `SCCCT_FN_PWM1: output_prepare_level <= !(counter_value <
               sel_val(compare_shadow_on, channel_value_register, compare_active_q));
            default: output_prepare_level <= output_prepare_level;
         endcase
      end
   end

   // Pin driven only in output mode with the channel gated on
   assign channel_out    = output_prepare_level;
   assign channel_out_en = channel_gate_on && !input_mode;

   // Interrupt lines are flag AND enable
   assign update_irq  = update_flag && update_irq_en;
   assign channel_irq = channel_event_flag && channel_event_irq_en;
endmodule
`default_nettype wire
